// ---- trace_capture.sv ----
// trace store, trigger, post-trigger freeze and register port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - trace store holds 256 entries
// - third breakpoint comparator qualifies stored cycles
// - comparators zero, one, two selectable as triggers
// - post counter advances on qualified cycles only
// - stop when post count equals delay
// - delay one keeps 254, trigger, one
// - rejected trigger references last qualified entry
// - early trigger reports fewer valid entries
// - qualifier uses breakpoint match, means store
// - qualifier accepts all or matching cycles
// - timing mode measures first to second event
// - time base microsecond, 100 ns setting ticking every two clocks (80 ns), cycle
// - each entry holds 64 signals
// - capture every qualified cycle, never stall target
// - store written circularly, oldest overwritten
// - freeze store then signal break
// - 24 bit timer wraps to zero
// - timer stops and holds on second event
module trace_capture (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cycle_capture_strobe,
	input wire logic [trace_pkg::ENTRY_W-1:0] cycle_signals,
	input wire logic [2:0] bp_match,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic exec_break,
	output logic trace_frozen
);
	import trace_pkg::*;
	logic [31:0] ctrl_ff;
	logic [7:0] delay_ff;
	logic [ENTRY_W-1:0] qval_ff;
	logic [ENTRY_W-1:0] qmsk_ff;
	logic [ENTRY_W-1:0] store_ff [DEPTH];
	logic [PTR_W-1:0] wptr_ff;
	logic [PTR_W:0] fill_ff;
	logic [PTR_W-1:0] ref_ff;
	logic ref_valid_ff;
	logic [7:0] post_ff;
	logic [PTR_W-1:0] rd_index_ff;
	logic [31:0] reg_rdata_ff;
	logic exec_break_ff;
	logic trace_frozen_ff;
	cap_state_t state_ff;
	logic trace_qualify_match;
	logic trig_hit;
	logic store_en;
	logic arm_pulse;
	logic [TIMER_W-1:0] timer_count;
	logic timer_running;
	logic [PTR_W-1:0] rd_slot;

	// masked compare with the same value/mask form as a breakpoint
	function automatic logic qual_hit(input logic [ENTRY_W-1:0] sig,
		input logic [ENTRY_W-1:0] val, input logic [ENTRY_W-1:0] msk, input logic all);
		qual_hit = all || (((sig ^ val) & msk) == '0);
	endfunction

	// qualifier: comparator three acts as store enable, not a halt
	always_comb begin
		trace_qualify_match = qual_hit(cycle_signals, qval_ff, qmsk_ff,
			ctrl_ff[CTRL_QALL]) && bp_match[2];
	end

	// any selected trigger comparator may fire
	assign trig_hit = |(bp_match & ctrl_ff[CTRL_TRIG_LSB +: 3]);
	assign store_en = cycle_capture_strobe && trace_qualify_match &&
		(state_ff == ST_PRE || state_ff == ST_POST);
	assign arm_pulse = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_ARM];

	// software writable configuration
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
			delay_ff <= DELAY_RST;
			qval_ff <= '0;
			qmsk_ff <= '0;
			rd_index_ff <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_CTRL: ctrl_ff <= reg_wdata & 32'h0000_00FE;
				ADDR_DELAY: delay_ff <= reg_wdata[7:0];
				ADDR_RD_INDEX: rd_index_ff <= reg_wdata[7:0];
				ADDR_QUAL_VAL_LO: qval_ff[31:0] <= reg_wdata;
				ADDR_QUAL_VAL_HI: qval_ff[63:32] <= reg_wdata;
				ADDR_QUAL_MSK_LO: qmsk_ff[31:0] <= reg_wdata;
				ADDR_QUAL_MSK_HI: qmsk_ff[63:32] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// store writes take no handshake, so the target never waits
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_slot
			always_ff @(posedge sys_clk) begin
				if (store_en && wptr_ff == PTR_W'(i)) begin
					store_ff[i] <= cycle_signals;
				end
			end
		end
	endgenerate

	// capture sequencer: pre-trigger, post-trigger, frozen
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			wptr_ff <= 8'h00;
			fill_ff <= 9'h000;
			post_ff <= 8'h00;
			ref_ff <= 8'h00;
			ref_valid_ff <= 1'b0;
		end else if (arm_pulse) begin
			state_ff <= ST_PRE;
			wptr_ff <= 8'h00;
			fill_ff <= 9'h000;
			post_ff <= 8'h00;
			ref_valid_ff <= 1'b0;
		end else begin
			if (store_en) begin
				wptr_ff <= wptr_ff + 8'h01;
				if (fill_ff != 9'(DEPTH)) begin
					fill_ff <= fill_ff + 9'h001;
				end
				if (!trace_frozen_ff && !ref_valid_ff && state_ff == ST_PRE) begin
					ref_ff <= wptr_ff;
				end
			end
			case (state_ff)
				ST_IDLE: ;
				ST_PRE: begin
					if (cycle_capture_strobe && trig_hit) begin
						state_ff <= ST_POST;
						ref_valid_ff <= 1'b1;
						if (!store_en) begin
							ref_ff <= wptr_ff - 8'h01;
						end
					end
				end
				ST_POST: begin
					if (store_en) begin
						post_ff <= post_ff + 8'h01;
						if (post_ff + 8'h01 == delay_ff) begin
							state_ff <= ST_FROZEN;
						end
					end
				end
				ST_FROZEN: ;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// break follows the freeze by one cycle
	always_ff @(posedge sys_clk) begin
		if (rst || arm_pulse) begin
			trace_frozen_ff <= 1'b0;
			exec_break_ff <= 1'b0;
		end else begin
			trace_frozen_ff <= state_ff == ST_FROZEN;
			exec_break_ff <= trace_frozen_ff;
		end
	end

	interval_timer u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(ctrl_ff[CTRL_TIMING]),
		.start_evt(cycle_capture_strobe && bp_match[0]),
		.stop_evt(cycle_capture_strobe && bp_match[1]),
		.bus_cycle(cycle_capture_strobe),
		.timebase(ctrl_ff[CTRL_TB_LSB +: 2]),
		.running(timer_running),
		.count(timer_count)
	);

	// read index counts back from the newest entry
	assign rd_slot = wptr_ff - 8'h01 - rd_index_ff;

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge sys_clk) begin
		if (rst || !reg_rd) begin
			reg_rdata_ff <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				ADDR_CTRL: reg_rdata_ff <= ctrl_ff;
				ADDR_DELAY: reg_rdata_ff <= {24'h000000, delay_ff};
				ADDR_STATUS: reg_rdata_ff <= {4'h0, ref_ff, post_ff, timer_running,
					fill_ff, exec_break_ff, trace_frozen_ff};
				ADDR_TIMER: reg_rdata_ff <= {8'h00, timer_count};
				ADDR_RD_INDEX: reg_rdata_ff <= {24'h000000, rd_index_ff};
				ADDR_ENTRY_LO: reg_rdata_ff <= store_ff[rd_slot][31:0];
				ADDR_ENTRY_HI: reg_rdata_ff <= store_ff[rd_slot][63:32];
				ADDR_QUAL_VAL_LO: reg_rdata_ff <= qval_ff[31:0];
				ADDR_QUAL_VAL_HI: reg_rdata_ff <= qval_ff[63:32];
				ADDR_QUAL_MSK_LO: reg_rdata_ff <= qmsk_ff[31:0];
				ADDR_QUAL_MSK_HI: reg_rdata_ff <= qmsk_ff[63:32];
				default: reg_rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_ff;
	assign exec_break = exec_break_ff;
	assign trace_frozen = trace_frozen_ff;

	frozen_no_store_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_FROZEN && !arm_pulse) |=> $stable(wptr_ff))
		else $error("store written while frozen");
	break_after_freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(exec_break_ff) |-> $past(trace_frozen_ff))
		else $error("break before freeze");
	post_count_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_POST && store_en && post_ff + 8'h01 == delay_ff && !arm_pulse)
		|=> state_ff == ST_FROZEN ##1 trace_frozen_ff ##1 exec_break_ff)
		else $error("capture did not stop at delay count");
	post_only_qual_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_POST && !store_en && !arm_pulse) |=> $stable(post_ff))
		else $error("post counter moved without a stored cycle");
	qual_gates_store_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!bp_match[2] && !arm_pulse) |=> $stable(wptr_ff))
		else $error("unqualified cycle stored");
	store_circular_a: assert property (@(posedge sys_clk) disable iff (rst)
		(store_en && wptr_ff == 8'hFF && !arm_pulse) |=> wptr_ff == 8'h00)
		else $error("store pointer did not wrap");
	fill_capped_a: assert property (@(posedge sys_clk) disable iff (rst)
		fill_ff <= 9'(DEPTH))
		else $error("fill count above capacity");
	trig_to_post_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_PRE && cycle_capture_strobe && trig_hit && !arm_pulse)
		|=> state_ff == ST_POST)
		else $error("selected trigger ignored");

	// reference slot, fill count, stored data, qualifier, re-arm, break hold and read port
	ref_no_store_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_PRE && cycle_capture_strobe && trig_hit && !store_en && !arm_pulse)
		|=> ref_ff == $past(wptr_ff) - 8'h01)
		else $error("reference slot not the last qualified entry");
	ref_stored_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == ST_PRE && cycle_capture_strobe && trig_hit && store_en && !arm_pulse)
		|=> ref_ff == $past(wptr_ff))
		else $error("reference slot not the trigger entry");
	fill_count_a: assert property (@(posedge sys_clk) disable iff (rst)
		(store_en && fill_ff != 9'(DEPTH) && !arm_pulse)
		|=> fill_ff == $past(fill_ff) + 9'h001)
		else $error("fill count missed a stored entry");
	store_data_a: assert property (@(posedge sys_clk) disable iff (rst)
		store_en |=> store_ff[$past(wptr_ff)] == $past(cycle_signals))
		else $error("stored entry differs from sampled signals");
	qual_reject_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!ctrl_ff[CTRL_QALL] && ((cycle_signals ^ qval_ff) & qmsk_ff) != '0 && !arm_pulse)
		|=> $stable(wptr_ff))
		else $error("cycle stored despite failed compare");
	arm_clears_a: assert property (@(posedge sys_clk) disable iff (rst)
		arm_pulse |=> (state_ff == ST_PRE && fill_ff == 9'h000 && !trace_frozen_ff))
		else $error("arm did not restart the run");
	break_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
		(exec_break_ff && !arm_pulse) |=> exec_break_ff)
		else $error("break dropped before re-arm");
	read_idle_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> reg_rdata_ff == 32'h0000_0000)
		else $error("read data outside the answer cycle");
endmodule
`default_nettype wire

// ---- trace_pkg.sv ----
// shared constants and types for the bus cycle trace capture block
package trace_pkg;
	localparam int ENTRY_W = 64;
	localparam int DEPTH = 256;
	localparam int PTR_W = 8;
	localparam int TIMER_W = 24;
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TB_US_NS = 1000;
	localparam int TB_100NS_NS = 100;
	localparam int TB_US_CYC = TB_US_NS / CLK_PERIOD_NS;
	localparam int TB_100NS_CYC = (TB_100NS_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(TB_100NS_NS / CLK_PERIOD_NS);
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DELAY = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_TIMER = 8'h0C;
	localparam logic [7:0] ADDR_RD_INDEX = 8'h10;
	localparam logic [7:0] ADDR_ENTRY_LO = 8'h14;
	localparam logic [7:0] ADDR_ENTRY_HI = 8'h18;
	localparam logic [7:0] ADDR_QUAL_VAL_LO = 8'h1C;
	localparam logic [7:0] ADDR_QUAL_VAL_HI = 8'h20;
	localparam logic [7:0] ADDR_QUAL_MSK_LO = 8'h24;
	localparam logic [7:0] ADDR_QUAL_MSK_HI = 8'h28;
	localparam int CTRL_ARM = 0;
	localparam int CTRL_TIMING = 1;
	localparam int CTRL_TRIG_LSB = 2;
	localparam int CTRL_TB_LSB = 5;
	localparam int CTRL_QALL = 7;
	localparam logic [7:0] DELAY_RST = 8'h01;
	localparam logic [31:0] CTRL_RST = 32'h0000_0080;
	typedef enum logic [1:0] {TB_US, TB_100NS, TB_CYCLE} timebase_t;
	typedef enum {ST_IDLE, ST_PRE, ST_POST, ST_FROZEN} cap_state_t;
endpackage

// ---- interval_timer.sv ----
// interval timer for event timing between two breakpoint events
`timescale 1ns/1ps
`default_nettype none
module interval_timer (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic start_evt,
	input wire logic stop_evt,
	input wire logic bus_cycle,
	input wire logic [1:0] timebase,
	output logic running,
	output logic [trace_pkg::TIMER_W-1:0] count
);
	import trace_pkg::*;
	logic [7:0] div_ff;
	logic tick;
	logic [7:0] div_top;
	logic running_ff;
	logic [TIMER_W-1:0] count_ff;

	// divider terminal count for the selected time base
	always_comb begin
		div_top = 8'(TB_US_CYC - 1);
		if (timebase == 2'(TB_100NS)) begin
			div_top = 8'(TB_100NS_CYC - 1);
		end
	end

	// tick source: divider pulse or one per bus cycle
	always_comb begin
		if (timebase == 2'(TB_CYCLE)) begin
			tick = bus_cycle;
		end else begin
			tick = running_ff && (div_ff == div_top);
		end
	end

	// divider restarts with the measurement so the first unit is whole
	always_ff @(posedge sys_clk) begin
		if (rst || !running_ff || div_ff == div_top) begin
			div_ff <= 8'h00;
		end else begin
			div_ff <= div_ff + 8'h01;
		end
	end

	// start on first event, hold on second
	always_ff @(posedge sys_clk) begin
		if (rst || !enable) begin
			running_ff <= 1'b0;
			count_ff <= 24'h000000;
		end else if (running_ff && stop_evt) begin
			running_ff <= 1'b0;
		end else if (!running_ff && start_evt) begin
			running_ff <= 1'b1;
			count_ff <= 24'h000000;
		end else if (running_ff && tick) begin
			count_ff <= count_ff + 24'h000001;
		end
	end

	assign running = running_ff;
	assign count = count_ff;

	stop_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
		(running_ff && stop_evt && enable) |=> (!running_ff && $stable(count_ff)))
		else $error("timer did not stop and hold");
	wrap_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		(running_ff && tick && enable && !stop_evt && count_ff == 24'hFFFFFF)
		|=> count_ff == 24'h000000)
		else $error("timer did not wrap to zero");
endmodule
`default_nettype wire

// ---- target_bus_model.sv ----
// target bus side model: issues bus cycles with chosen breakpoint matches
`timescale 1ns/1ps
`default_nettype none
module target_bus_model (
	input wire logic sys_clk,
	input wire logic [3:0] gap,
	output logic cycle_capture_strobe,
	output logic [trace_pkg::ENTRY_W-1:0] cycle_signals,
	output logic [2:0] bp_match
);
	import trace_pkg::*;
	logic [31:0] n;
	// quiet lines before the first cycle
	initial begin
		n = 32'h0;
		cycle_capture_strobe = 1'b0;
		cycle_signals = '0;
		bp_match = 3'h0;
	end
	// one target cycle: strobe for a clock, then gap plus one idle clocks
	// idle lines show the inverse so a stale value never looks valid
	task automatic cycle(input logic [2:0] bp);
		@(posedge sys_clk);
		cycle_capture_strobe <= 1'b1;
		cycle_signals <= {~n, n};
		bp_match <= bp;
		@(posedge sys_clk);
		cycle_capture_strobe <= 1'b0;
		cycle_signals <= {n, ~n};
		bp_match <= ~bp;
		n = n + 32'h1;
		repeat (gap) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ---- bus_cycle_trace_capture_bench.sv ----
// self-checking bench for the bus cycle trace capture block
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_trace_capture_bench;
	import trace_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] gap = 4'h0;
	logic [31:0] reg_rdata;
	logic exec_break;
	logic trace_frozen;
	logic strobe;
	logic [ENTRY_W-1:0] sigs;
	logic [2:0] bp;
	int fails = 0;
	int checked = 0;
	int e;
	logic [31:0] sq = 32'h0;
	logic [31:0] d;
	logic [31:0] t1;
	logic [31:0] s0;
	logic [7:0] ra [5] = '{ADDR_CTRL, ADDR_DELAY, ADDR_STATUS, ADDR_TIMER, 8'hFC};
	logic [31:0] rv [5] = '{CTRL_RST, {24'h0, DELAY_RST}, 32'h0, 32'h0, 32'h0};

	// 25 MHz system clock
	always #20 sys_clk = ~sys_clk;

	trace_capture uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.cycle_capture_strobe(strobe),
		.cycle_signals(sigs),
		.bp_match(bp),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.exec_break(exec_break),
		.trace_frozen(trace_frozen)
	);

	target_bus_model model (
		.sys_clk(sys_clk),
		.gap(gap),
		.cycle_capture_strobe(strobe),
		.cycle_signals(sigs),
		.bp_match(bp)
	);

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// register port: one strobe cycle, read data taken one edge later
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		v = reg_rdata;
	endtask

	// bench keeps its own sequence count, matching the model's
	task automatic cyc(input logic [2:0] b);
		model.cycle(b);
		sq++;
	endtask

	// a 64-bit entry travels as two halves at one index
	task automatic chk_entry(input logic [7:0] i, input logic [31:0] s);
		logic [31:0] lo;
		logic [31:0] hi;
		wr(ADDR_RD_INDEX, {24'h0, i});
		rd(ADDR_ENTRY_LO, lo);
		rd(ADDR_ENTRY_HI, hi);
		check("entry", {hi, lo}, {~s, s});
	endtask

	// bounded wait for freeze; break must trail it by one clock
	task automatic wait_frozen();
		e = 0;
		while (trace_frozen !== 1'b1 && e < 12) begin
			@(posedge sys_clk);
			e++;
		end
		check("freeze wait", e < 12, 1'b1);
		check("break before freeze", exec_break, 1'b0);
		@(posedge sys_clk);
		check("break", exec_break, 1'b1);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		check("frozen at reset", trace_frozen, 1'b0);
		// reset values and an unmapped read
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], d);
			check("reset register", d, rv[i]);
		end
		// read data stands for one cycle only, then returns to zero
		rd(ADDR_CTRL, d);
		@(posedge sys_clk);
		check("read data one cycle", reg_rdata, 32'h0);
		// wrap the store, trigger on bp0, three post entries
		wr(ADDR_DELAY, 32'h3);
		wr(ADDR_CTRL, 32'h85);
		repeat (300) cyc(3'b100);
		s0 = sq;
		cyc(3'b101);
		repeat (2) cyc(3'b100);
		check("frozen early", trace_frozen, 1'b0);
		cyc(3'b100);
		wait_frozen();
		repeat (3) cyc(3'b101);
		rd(ADDR_STATUS, d);
		check("fill", d[10:2], 9'h100);
		check("post count", d[19:12], 8'h03);
		chk_entry(8'h00, s0 + 32'h3);
		chk_entry(8'h03, s0);
		chk_entry(8'hFF, s0 - 32'hFC);
		// re-arm, delay one, unqualified trigger on bp1
		wr(ADDR_DELAY, 32'h1);
		wr(ADDR_CTRL, 32'h89);
		repeat (2) @(posedge sys_clk);
		check("frozen cleared", trace_frozen, 1'b0);
		repeat (5) cyc(3'b100);
		s0 = sq - 32'h1;
		cyc(3'b010);
		repeat (2) cyc(3'b000);
		check("frozen on unqualified", trace_frozen, 1'b0);
		cyc(3'b100);
		wait_frozen();
		rd(ADDR_STATUS, d);
		check("fill early", d[10:2], 9'h006);
		chk_entry(8'h01, s0);
		chk_entry(8'h00, s0 + 32'h4);
		// masked qualifier keeps even offsets; bp1 triggers with bp0 also selected
		s0 = sq;
		wr(ADDR_QUAL_VAL_LO, s0);
		wr(ADDR_QUAL_MSK_LO, 32'h1);
		wr(ADDR_DELAY, 32'h2);
		wr(ADDR_CTRL, 32'h0D);
		repeat (2) cyc(3'b100);
		cyc(3'b110);
		repeat (4) cyc(3'b100);
		wait_frozen();
		rd(ADDR_STATUS, d);
		check("masked fill", d[10:2], 9'h004);
		check("masked post count", d[19:12], 8'h02);
		check("reference slot", d[27:20], 8'h01);
		chk_entry(8'h00, s0 + 32'h6);
		chk_entry(8'h01, s0 + 32'h4);
		chk_entry(8'h02, s0 + 32'h2);
		// each time base over 50 bus cycles of 5 clocks, 250 clocks
		gap <= 4'h3;
		for (int tb = 0; tb < 3; tb++) begin
			wr(ADDR_CTRL, 32'h80);
			rd(ADDR_TIMER, d);
			check("timer cleared", d, 32'h0);
			wr(ADDR_CTRL, 32'h82 | (tb << 5));
			cyc(3'b001);
			repeat (49) cyc(3'b000);
			cyc(3'b010);
			rd(ADDR_TIMER, t1);
			e = (tb == 0) ? 10 : (tb == 1) ? 125 : 50;
			check("timer range", (t1 + 1 >= e) && (t1 <= e + 1), 1'b1);
			repeat (40) @(posedge sys_clk);
			rd(ADDR_TIMER, d);
			check("timer held", d, t1);
		end
		// second reset in mid-run clears the run
		wr(ADDR_CTRL, 32'h85);
		repeat (3) cyc(3'b100);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(ADDR_STATUS, d);
		check("status after reset", d, 32'h0);
		summarize();
	end

	// watchdog sized well past the few thousand clocks the tests need
	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
